// [verilog/smie_defines.svh]
// register offsets, field positions and reset values of the event block
`ifndef SMIE_DEFINES_SVH
`define SMIE_DEFINES_SVH

`define SMIE_OFF_STS2    8'h13
`define SMIE_OFF_EN2     8'h15
`define SMIE_OFF_MSC     8'h16

`define SMIE_BIT_MOUSE   0
`define SMIE_BIT_KBD     1
`define SMIE_BIT_IR      2
`define SMIE_BIT_BTN     3
`define SMIE_BIT_KBC     4
`define SMIE_BIT_WAKE    6
`define SMIE_BIT_OUT     7
`define SMIE_EN2_WMASK   8'hdf
`define SMIE_EN2_RST     8'h00

`define SMIE_BIT_POR     4
`define SMIE_MSC_RST     8'h00
`define SMIE_NUM_EDGE    4

`endif

// [verilog/smie_pkg.sv]
// shared types of the event block
package smie_pkg;
  typedef logic [7:0]  smie_byte_t;
  typedef logic [15:0] smie_ioaddr_t;
  typedef enum logic [1:0] {
    SMIE_SEL_NONE = 2'b00,
    SMIE_SEL_STS2 = 2'b01,
    SMIE_SEL_EN2  = 2'b10,
    SMIE_SEL_MSC  = 2'b11
  } smie_regsel_e;
endpackage

// [verilog/smie_route_if.sv]
// group interrupt sources and routing results between top and router
`timescale 1ns/100ps
`default_nettype none
interface smie_route_if;
  logic [4:0] srcLevel;
  logic [4:0] srcEnable;
  logic       otherReq;
  logic       wakeEn;
  logic       outEn;
  logic       serSel;
  logic       groupActive;
  logic       pinOe;
  logic       serReq;
  logic       wakeReq;
  modport top (output srcLevel, srcEnable, otherReq, wakeEn, outEn, serSel,
               input groupActive, pinOe, serReq, wakeReq);
  modport route (input srcLevel, srcEnable, otherReq, wakeEn, outEn, serSel,
                 output groupActive, pinOe, serReq, wakeReq);
endinterface
`default_nettype wire

// [verilog/smie_edge_flag.sv]
// synchronised input with edge detect and sticky event flag
`timescale 1ns/100ps
`default_nettype none
module smie_edge_flag (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  input  wire logic clrReq,
  output logic      level,
  output logic      edgePulse,
  output logic      flag
);
  logic syncA_q, syncB_q, syncC_q;
  logic stable_q, primed_q, flag_q;
  logic [1:0] fill_q;
  logic agree;
  logic filled;
  logic flag_d;

  assign agree     = (syncB_q == syncC_q);
  // prime only once the pin has reached the last stage, so a pin idling
  // high after reset is not taken for an edge
  assign filled    = (fill_q == 2'h3);
  assign edgePulse = agree && primed_q && (syncC_q != stable_q);
  assign flag_d    = edgePulse | (flag_q & ~clrReq); // set wins
  assign level     = stable_q;
  assign flag      = flag_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      syncA_q  <= 1'b0;
      syncB_q  <= 1'b0;
      syncC_q  <= 1'b0;
      stable_q <= 1'b0;
      primed_q <= 1'b0;
      fill_q   <= 2'h0;
      flag_q   <= 1'b0;
    end else begin
      syncA_q  <= pinIn;
      syncB_q  <= syncA_q;
      syncC_q  <= syncB_q;
      stable_q <= agree ? syncC_q : stable_q;
      primed_q <= primed_q | (agree & filled);
      fill_q   <= filled ? fill_q : fill_q + 2'h1;
      flag_q   <= flag_d;
    end
  end

  edge_sets_flag_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    edgePulse |=> flag_q)
    else $error("edge did not set flag");

  edge_both_ways_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (primed_q && syncB_q == syncC_q && syncC_q != stable_q) |=>
      (stable_q == $past(syncC_q)))
    else $error("agreed change not taken on either edge");
endmodule // smie_edge_flag
`default_nettype wire

// [verilog/smie_smi_route.sv]
// group management interrupt combine and routing
`timescale 1ns/100ps
`default_nettype none
module smie_smi_route (
  smie_route_if.route rt
);
  logic anySrc;

  assign anySrc         = |(rt.srcLevel & rt.srcEnable);
  assign rt.groupActive = anySrc | rt.otherReq;
  assign rt.wakeReq     = rt.wakeEn & rt.groupActive;
  // pin floats unless enabled and the serial frame is not chosen
  assign rt.pinOe       = rt.outEn & ~rt.serSel;
  assign rt.serReq      = rt.outEn & rt.serSel & rt.groupActive;
endmodule // smie_smi_route
`default_nettype wire

// [verilog/smie_top.sv]
// management interrupt enables and dual-edge gpio event status
`timescale 1ns/100ps
`default_nettype none
`include "smie_defines.svh"
module smie_top #(
  parameter int NUM_EDGE = `SMIE_NUM_EDGE
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire smie_pkg::smie_ioaddr_t powerBlockBase,
  input  wire smie_pkg::smie_ioaddr_t ioAddr,
  input  wire logic                 ioWrStb,
  input  wire logic                 ioRdStb,
  input  wire smie_pkg::smie_byte_t ioWrData,
  output smie_pkg::smie_byte_t      ioRdData,
  input  wire logic                 mouseIrqSrc,
  input  wire logic                 keyboardIrqSrc,
  input  wire logic                 buttonIrqSrc,
  input  wire logic                 kbcPinRoute,
  input  wire logic                 otherSmiReq,
  input  wire logic                 irqMuxSerSel,
  input  wire logic                 infraredRxIn,
  input  wire logic [NUM_EDGE-1:0]  edgeInputIn,
  input  wire logic                 gpioGroupEnOne,
  input  wire logic                 gpioGroupEnTwo,
  input  wire logic [NUM_EDGE-1:0]  dualEdgeSel,
  input  wire logic [NUM_EDGE-1:0]  gpioPolarity,
  input  wire logic [NUM_EDGE-1:0]  gpioDirOut,
  input  wire logic [NUM_EDGE-1:0]  gpioOpenDrain,
  input  wire logic [NUM_EDGE-1:0]  gpioOutVal,
  output logic      [NUM_EDGE-1:0]  gpioPinOut,
  output logic      [NUM_EDGE-1:0]  gpioPinOe,
  output logic      [NUM_EDGE-1:0]  gpioDataBit,
  output logic      [NUM_EDGE-1:0]  dualEdgeIrq,
  output logic                      gpioGroupIrqOne,
  output logic                      gpioGroupIrqTwo,
  input  wire logic                 standbyPorIn,
  input  wire logic                 systemOnNIn,
  output logic                      sciEvent,
  output logic                      groupMgmtIrqN,
  output logic                      groupMgmtIrqOe,
  output logic                      smiSerIrqReq,
  output logic                      smiWakeReq
);
  import smie_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  smie_byte_t        en2_q;
  smie_byte_t        en2_d;
  smie_byte_t        rdData_q;
  smie_byte_t        rdMux;
  smie_byte_t        mscView;
  smie_byte_t        sts2View;
  smie_regsel_e      regSel;
  smie_ioaddr_t      addrSts2;
  smie_ioaddr_t      addrEn2;
  smie_ioaddr_t      addrMsc;
  logic              wrEn2;
  logic              wrMsc;
  logic              rdSts2;
  logic              btnFlag_q;
  logic              btnFlag_d;
  logic              sci_q;
  logic              irFlag;
  logic              irEdge;
  logic              porFlag;
  logic              porClr;
  logic              sysOnLevel;
  logic              sysOnEdge;
  logic              sysOnFall;
  logic [NUM_EDGE-1:0] edgeLevel;
  logic [NUM_EDGE-1:0] edgePulse;
  logic [NUM_EDGE-1:0] edgeFlag;
  logic [NUM_EDGE-1:0] edgeClr;
  logic [NUM_EDGE-1:0] groupEn;
  logic [NUM_EDGE-1:0] dataBit_q;

  assign addrSts2 = powerBlockBase + {8'h00, `SMIE_OFF_STS2};
  assign addrEn2  = powerBlockBase + {8'h00, `SMIE_OFF_EN2};
  assign addrMsc  = powerBlockBase + {8'h00, `SMIE_OFF_MSC};

  assign regSel = (ioAddr == addrSts2) ? SMIE_SEL_STS2 :
                  (ioAddr == addrEn2)  ? SMIE_SEL_EN2  :
                  (ioAddr == addrMsc)  ? SMIE_SEL_MSC  : SMIE_SEL_NONE;

  assign wrEn2  = ioWrStb && (regSel == SMIE_SEL_EN2);
  assign wrMsc  = ioWrStb && (regSel == SMIE_SEL_MSC);
  assign rdSts2 = ioRdStb && (regSel == SMIE_SEL_STS2);

  ////////////////////////////////////////////////////////////////////////////
  // second enable register

  // reserved bit 5 is not stored
  assign en2_d = wrEn2 ? (ioWrData & `SMIE_EN2_WMASK) : en2_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en2_q <= `SMIE_EN2_RST;
    end else begin
      en2_q <= en2_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event inputs

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EDGE; gi++) begin : gEdge
      assign edgeClr[gi] = wrMsc && ioWrData[gi];
      smie_edge_flag uEdge (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pinIn     (edgeInputIn[gi]),
        .clrReq    (edgeClr[gi]),
        .level     (edgeLevel[gi]),
        .edgePulse (edgePulse[gi]),
        .flag      (edgeFlag[gi])
      );
      // first half of the pins belong to group one, the rest to group two
      assign groupEn[gi] = (gi < NUM_EDGE / 2) ? gpioGroupEnOne
                                               : gpioGroupEnTwo;
    end
  endgenerate

  // receive line edges, cleared by a read of source status
  smie_edge_flag uIr (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pinIn     (infraredRxIn),
    .clrReq    (rdSts2),
    .level     (),
    .edgePulse (irEdge),
    .flag      (irFlag)
  );

  assign porClr = wrMsc && ioWrData[`SMIE_BIT_POR];

  smie_edge_flag uPor (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pinIn     (standbyPorIn),
    .clrReq    (porClr),
    .level     (),
    .edgePulse (),
    .flag      (porFlag)
  );

  smie_edge_flag uSysOn (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pinIn     (systemOnNIn),
    .clrReq    (1'b0),
    .level     (sysOnLevel),
    .edgePulse (sysOnEdge),
    .flag      ()
  );

  // level still shows the old high value while the edge pulse stands
  assign sysOnFall = sysOnEdge && sysOnLevel;
  assign btnFlag_d = buttonIrqSrc | (btnFlag_q & ~rdSts2); // set wins

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      btnFlag_q <= 1'b0;
      sci_q     <= 1'b0;
    end else begin
      btnFlag_q <= btnFlag_d;
      sci_q     <= sysOnFall && porFlag;
    end
  end

  assign sciEvent = sci_q;

  ////////////////////////////////////////////////////////////////////////////
  // gpio pin function

  // dual-edge mode turns the driver off whatever the pin config says
  assign gpioPinOut  = gpioOutVal;
  assign gpioPinOe   = ~dualEdgeSel & gpioDirOut
                     & (~gpioOpenDrain | ~gpioOutVal);
  assign dualEdgeIrq = edgeFlag & dualEdgeSel & groupEn;
  assign gpioGroupIrqOne = |dualEdgeIrq[NUM_EDGE/2-1:0];
  assign gpioGroupIrqTwo = |dualEdgeIrq[NUM_EDGE-1:NUM_EDGE/2];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dataBit_q <= '0;
    end else begin
      dataBit_q <= edgeLevel ^ gpioPolarity;
    end
  end

  assign gpioDataBit = dataBit_q;

  ////////////////////////////////////////////////////////////////////////////
  // group interrupt routing

  smie_route_if rt ();

  assign rt.srcLevel  = {kbcPinRoute, btnFlag_q, irFlag,
                         keyboardIrqSrc, mouseIrqSrc};
  assign rt.srcEnable = en2_q[`SMIE_BIT_KBC:`SMIE_BIT_MOUSE];
  assign rt.otherReq  = otherSmiReq;
  assign rt.wakeEn    = en2_q[`SMIE_BIT_WAKE];
  assign rt.outEn     = en2_q[`SMIE_BIT_OUT];
  assign rt.serSel    = irqMuxSerSel;

  smie_smi_route uRoute (
    .rt (rt.route)
  );

  assign groupMgmtIrqN  = ~rt.groupActive;
  assign groupMgmtIrqOe = rt.pinOe;
  assign smiSerIrqReq   = rt.serReq;
  assign smiWakeReq     = rt.wakeReq;

  ////////////////////////////////////////////////////////////////////////////
  // read path

  assign mscView  = {3'b000, porFlag, edgeFlag};
  assign sts2View = {3'b000, kbcPinRoute, btnFlag_q, irFlag,
                     keyboardIrqSrc, mouseIrqSrc};

  always_comb begin
    unique case (regSel)
      SMIE_SEL_STS2: rdMux = sts2View;
      SMIE_SEL_EN2:  rdMux = en2_q;
      SMIE_SEL_MSC:  rdMux = mscView;
      SMIE_SEL_NONE: rdMux = 8'hff;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
    end else if (ioRdStb) begin
      rdData_q <= rdMux;
    end
  end

  assign ioRdData = rdData_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  mouse_gate_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (mouseIrqSrc && en2_q[`SMIE_BIT_MOUSE]) |-> !groupMgmtIrqN)
    else $error("enabled mouse source did not assert group");

  group_idle_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (en2_q[4:0] == 5'h00 && !otherSmiReq) |-> groupMgmtIrqN)
    else $error("group asserted with all sources disabled");

  kbc_route_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (kbcPinRoute && en2_q[`SMIE_BIT_KBC]) |-> !groupMgmtIrqN)
    else $error("keyboard pin route did not assert group");

  wake_gate_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    smiWakeReq == (en2_q[`SMIE_BIT_WAKE] && !groupMgmtIrqN))
    else $error("wake request does not follow gate");

  pin_float_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !en2_q[`SMIE_BIT_OUT] |-> (!groupMgmtIrqOe && !smiSerIrqReq))
    else $error("group output driven while disabled");

  mux_select_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    en2_q[`SMIE_BIT_OUT] |-> (groupMgmtIrqOe == !irqMuxSerSel))
    else $error("pin enable does not follow mux select");

  reset_zero_a: assert property (@(posedge sys_clk)
    !rst_n |=> (en2_q == 8'h00 && mscView == 8'h00))
    else $error("registers not zero after reset");

  wr_one_clr_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (wrMsc && ioWrData[0] && !edgePulse[0]) |=> !edgeFlag[0])
    else $error("write one did not clear edge flag");

  wr_zero_keep_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (wrMsc && !ioWrData[`SMIE_BIT_POR] && porFlag) |=> porFlag)
    else $error("write zero cleared power-on flag");

  dual_irq_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    dualEdgeIrq == (edgeFlag & dualEdgeSel & groupEn))
    else $error("dual-edge irq without status and enable");

  rsvd_read_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (ioRdStb && regSel == SMIE_SEL_MSC) |=> ioRdData[7:5] == 3'b000)
    else $error("reserved status bits read nonzero");

  sci_event_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (sysOnFall && porFlag) |=> sciEvent ##1 !sciEvent)
    else $error("switch-on after standby reset gave no event");

  ir_read_clr_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (rdSts2 && !irEdge) |=> !irFlag)
    else $error("status read did not clear infrared flag");
endmodule // smie_top
`default_nettype wire

// [tb/smie_top_tb.sv]
// self-checking bench of the management interrupt and edge event block
`timescale 1ns/100ps
`default_nettype none
module smie_top_tb;
  import smie_pkg::*;
  typedef struct {string nm; logic [23:0] v;} smie_note_s;

  logic         sys_clk, rst_n, ioWrStb, ioRdStb;
  smie_ioaddr_t powerBlockBase, ioAddr;
  smie_byte_t   ioWrData, ioRdData;
  logic         mouseIrqSrc, keyboardIrqSrc, buttonIrqSrc, kbcPinRoute;
  logic         otherSmiReq, irqMuxSerSel, infraredRxIn;
  logic [3:0]   edgeInputIn, dualEdgeSel, gpioPolarity, gpioDirOut;
  logic [3:0]   gpioOpenDrain, gpioOutVal, gpioPinOut, gpioPinOe;
  logic [3:0]   gpioDataBit, dualEdgeIrq;
  logic         gpioGroupEnOne, gpioGroupEnTwo;
  logic         gpioGroupIrqOne, gpioGroupIrqTwo;
  logic         standbyPorIn, systemOnNIn, sciEvent;
  logic         groupMgmtIrqN, groupMgmtIrqOe, smiSerIrqReq, smiWakeReq;
  logic         rdSeen, probeReq, irF, btnF;
  logic [7:0]   en2M, mscM;
  logic [23:0]  probeVal;
  smie_note_s   rdQ[$];
  smie_note_s   prQ[$];
  int           err_count, num_checks, sciCnt;

  smie_top #(.NUM_EDGE(4)) DUT (
    .sys_clk, .rst_n, .powerBlockBase, .ioAddr, .ioWrStb, .ioRdStb,
    .ioWrData, .ioRdData, .mouseIrqSrc, .keyboardIrqSrc, .buttonIrqSrc,
    .kbcPinRoute, .otherSmiReq, .irqMuxSerSel, .infraredRxIn, .edgeInputIn,
    .gpioGroupEnOne, .gpioGroupEnTwo, .dualEdgeSel, .gpioPolarity,
    .gpioDirOut, .gpioOpenDrain, .gpioOutVal, .gpioPinOut, .gpioPinOe,
    .gpioDataBit, .dualEdgeIrq, .gpioGroupIrqOne, .gpioGroupIrqTwo,
    .standbyPorIn, .systemOnNIn, .sciEvent, .groupMgmtIrqN,
    .groupMgmtIrqOe, .smiSerIrqReq, .smiWakeReq
  );

  assign probeVal = {groupMgmtIrqN, groupMgmtIrqOe, smiSerIrqReq, smiWakeReq,
                     gpioGroupIrqTwo, gpioGroupIrqOne, 2'b00, dualEdgeIrq,
                     gpioDataBit, gpioPinOe, gpioPinOut};

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // expected outputs from the bench's own register and flag model
  function automatic logic [23:0] expProbe();
    logic [4:0] sts;
    logic       act;
    logic [3:0] dIrq;
    sts  = {kbcPinRoute, btnF, irF, keyboardIrqSrc, mouseIrqSrc};
    act  = (|(sts & en2M[4:0])) | otherSmiReq;
    dIrq = mscM[3:0] & dualEdgeSel &
           {{2{gpioGroupEnTwo}}, {2{gpioGroupEnOne}}};
    return {~act, en2M[7] & ~irqMuxSerSel, en2M[7] & irqMuxSerSel & act,
            en2M[6] & act, |dIrq[3:2], |dIrq[1:0], 2'b00, dIrq,
            edgeInputIn ^ gpioPolarity,
            ~dualEdgeSel & gpioDirOut & (~gpioOpenDrain | ~gpioOutVal),
            gpioOutVal};
  endfunction

  task automatic report(input smie_note_s n, input logic [23:0] seen);
    num_checks++;
    if (seen !== n.v) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n.nm, n.v, seen);
    end
  endtask

  task automatic cmpRd(input smie_note_s n);
    report(n, {16'h0000, ioRdData});
  endtask

  task automatic cmpOut(input smie_note_s n);
    report(n, probeVal);
  endtask

  task automatic wr(input logic [7:0] off, input smie_byte_t d);
    ioAddr   = powerBlockBase + 16'(off);
    ioWrData = d;
    ioWrStb  = 1'b1;
    @(negedge sys_clk);
    ioWrStb = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] off, input smie_byte_t e);
    ioAddr  = powerBlockBase + 16'(off);
    ioRdStb = 1'b1;
    rdQ.push_back('{$sformatf("reg 0x%h", off), 24'(e)});
    @(negedge sys_clk);
    ioRdStb = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic probe();
    prQ.push_back('{"outputs", expProbe()});
    probeReq = 1'b1;
    @(negedge sys_clk);
    probeReq = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic endTest(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // monitor: results are matched against the oldest note
  always @(posedge sys_clk) begin
    if (rdSeen) cmpRd(rdQ.pop_front());
    if (probeReq) cmpOut(prQ.pop_front());
    if (sciEvent === 1'b1) sciCnt++;
    rdSeen <= ioRdStb;
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    smie_byte_t v;
    int         k;
    void'($urandom(32'he21d));
    rst_n = 1'b0;  ioWrStb = 1'b0;  ioRdStb = 1'b0;  ioAddr = '0;
    ioWrData = '0;  powerBlockBase = 16'($urandom) & 16'hff00;
    {mouseIrqSrc, keyboardIrqSrc, buttonIrqSrc, kbcPinRoute} = 4'h0;
    {otherSmiReq, irqMuxSerSel, infraredRxIn} = 3'b000;
    edgeInputIn = 4'h0;  dualEdgeSel = 4'h0;
    gpioGroupEnOne = 1'b0;  gpioGroupEnTwo = 1'b0;
    {gpioPolarity, gpioDirOut, gpioOpenDrain, gpioOutVal} = 16'($urandom);
    standbyPorIn = 1'b0;  systemOnNIn = 1'b1;
    probeReq = 1'b0;  irF = 1'b0;  btnF = 1'b0;
    en2M = 8'h00;  mscM = 8'h00;  err_count = 0;  num_checks = 0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h00);
    rd(8'h17, 8'hff);
    wr(8'h14, 8'h5a);
    rd(8'h15, 8'h00);
    probe();
    endTest("reset");

    repeat (12) begin
      {mouseIrqSrc, keyboardIrqSrc, kbcPinRoute, irqMuxSerSel} = 4'($urandom);
      otherSmiReq = ($urandom % 4) == 0;
      v = 8'($urandom);
      wr(8'h15, v);
      en2M = v & 8'hdf;
      rd(8'h15, en2M);
      probe();
    end
    endTest("routing");

    {mouseIrqSrc, keyboardIrqSrc, kbcPinRoute, otherSmiReq} = 4'h0;
    wr(8'h15, 8'hcc);
    en2M = 8'hcc;
    buttonIrqSrc = 1'b1;
    @(negedge sys_clk);
    buttonIrqSrc = 1'b0;
    infraredRxIn = 1'b1;
    repeat (7) @(negedge sys_clk);
    {irF, btnF} = 2'b11;
    probe();
    rd(8'h13, 8'h0c);
    {irF, btnF} = 2'b00;
    rd(8'h13, 8'h00);
    probe();
    endTest("sticky sources");

    for (k = 0; k < 4; k++) begin
      dualEdgeSel = 4'($urandom);
      dualEdgeSel[k] = (k != 2);
      gpioGroupEnOne = (k == 1);
      gpioGroupEnTwo = (k >= 2);
      edgeInputIn[k] = 1'b1;
      repeat (7) @(negedge sys_clk);
      mscM[k] = 1'b1;
      probe();
      wr(8'h16, 8'h00);
      rd(8'h16, mscM);
      wr(8'h16, 8'h01 << k);
      mscM[k] = 1'b0;
      rd(8'h16, mscM);
      edgeInputIn[k] = 1'b0;
      repeat (7) @(negedge sys_clk);
      mscM[k] = 1'b1;
      probe();
    end
    wr(8'h16, 8'he0);
    rd(8'h16, mscM);
    endTest("edge events");

    standbyPorIn = 1'b1;
    repeat (7) @(negedge sys_clk);
    mscM[4] = 1'b1;
    rd(8'h16, mscM);
    wr(8'h16, 8'h00);
    rd(8'h16, mscM);
    k = sciCnt;
    systemOnNIn = 1'b0;
    repeat (12) @(negedge sys_clk);
    report('{"sci pulses", 24'd1}, 24'(sciCnt - k));
    wr(8'h16, 8'hff);
    mscM = 8'h00;
    rd(8'h16, mscM);
    endTest("standby power-on");

    repeat (4) @(negedge sys_clk);
    stop_test();
  end
endmodule // smie_top_tb
`default_nettype wire
